/* File: hdl/lcd_channel.sv */
// one receive channel: zero-substitution decoder, violation flag, loss of signal monitor
`timescale 1ns/100ps

// Operation
// - E3: 000V/B00V replaced by four zeros
// - E3: pulse violation on bad V or 4 zeros
// - control bit D3 zero enables decoder
// - strap pin low enables, high bypasses decoder
// - declare loss: output high, status one
// - clear loss when amplitude and pulses return
// - E3 loss changes 10 to 255 UI late
// - DS3 loss is analog OR digital loss
// - analog loss sets low, clears high level
// - status D2 reports analog loss state
// - control D2 one disables analog loss
// - DS3/STS-1: 160 zeros declare digital loss
// - DS3/STS-1: clear after four 32-bit windows of ten ones, E3 after one
// - status D1 digital, D3 loss, D4 lock
// - B3ZS: 00V/B0V replaced by three zeros
// - B3ZS: pulse violation on bad V or 3 zeros
// - control D1 disables digital, both suppress all
module lcd_channel
   import lcd_pkg::*;
#(
   parameter int DLOS_ZEROS = LCD_DLOS_ZEROS,
   parameter int E3_QUAL = LCD_E3_QUAL_UI
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire lcd_rate_e i_rate_mode,
   input wire logic i_host_mode,
   input wire logic i_codec_bypass,
   input wire lcd_rail_s i_line,
   input wire logic i_amp_below_declare,
   input wire logic i_amp_above_clear,
   input wire logic i_lock_loss_flag,
   input wire logic i_drive_monitor_flag,
   input wire logic [2:0] i_addr,
   input wire logic [LCD_REG_W-1:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [LCD_REG_W-1:0] o_rd_data,
   output lcd_rail_s o_data,
   output logic o_code_violation_pulse,
   output logic o_loss_of_signal_out,
   output logic o_equalizer_enable,
   output logic o_irq
);
   initial begin
      if (DLOS_ZEROS < 128 || DLOS_ZEROS > 192 || E3_QUAL < 1 ||
          LCD_E3_ZEROS + E3_QUAL < LCD_E3_MIN_UI ||
          2 * LCD_WIN_BITS + E3_QUAL > LCD_E3_MAX_UI) begin
         $error("lcd_channel: loss timing parameters out of range");
      end
   end

   // ****************************************************************
   // register file
   // ****************************************************************
   logic [LCD_REG_W-1:0] ctrl_reg, ctrl_next;
   logic [LCD_REG_W-1:0] mask_reg, mask_next;
   logic [LCD_REG_W-1:0] istat_reg, istat_next;
   logic [LCD_REG_W-1:0] rd_reg, rd_next;
   logic [LCD_REG_W-1:0] status;
   logic [LCD_REG_W-1:0] events;
   logic bypass, alos_dis, dlos_dis;
   logic alos_reg, dlos_q, los_reg;

   assign bypass = i_host_mode ? ctrl_reg[LCD_CT_BYPASS] : i_codec_bypass;
   assign alos_dis = ctrl_reg[LCD_CT_ALOS_DIS];
   assign dlos_dis = ctrl_reg[LCD_CT_DLOS_DIS];

   always_comb begin
      status = '0;
      status[LCD_ST_DRIVE_MON] = i_drive_monitor_flag;
      status[LCD_ST_DLOS] = dlos_q;
      status[LCD_ST_ALOS] = alos_reg;
      status[LCD_ST_LOS] = los_reg;
      status[LCD_ST_LOCK] = i_lock_loss_flag;
   end

   always_comb begin
      ctrl_next = ctrl_reg;
      mask_next = mask_reg;
      rd_next = '0;
      istat_next = istat_reg;
      if (i_wr && i_addr == LCD_OFS_CONTROL) begin
         ctrl_next = i_wr_data;
      end
      if (i_wr && i_addr == LCD_OFS_IRQ_MASK) begin
         mask_next = i_wr_data;
      end
      if (i_rd) begin
         case (i_addr)
            LCD_OFS_STATUS: rd_next = status;
            LCD_OFS_CONTROL: rd_next = ctrl_reg;
            LCD_OFS_IRQ_STATUS: rd_next = istat_reg;
            LCD_OFS_IRQ_MASK: rd_next = mask_reg;
            default: rd_next = '0;
         endcase
         if (i_addr == LCD_OFS_IRQ_STATUS) begin
            istat_next = '0;
         end
      end
      // a new event in the clearing cycle survives
      istat_next = istat_next | events;
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_reg <= LCD_CONTROL_RESET;
         mask_reg <= '0;
         istat_reg <= '0;
         rd_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         mask_reg <= mask_next;
         istat_reg <= istat_next;
         rd_reg <= rd_next;
      end
   end

   assign o_rd_data = rd_reg;
   assign o_irq = |(istat_reg & mask_reg);
   assign o_equalizer_enable = ctrl_reg[LCD_CT_EQ_EN];

   // ****************************************************************
   // zero-substitution decoder
   // ****************************************************************
   lcd_rail_s [LCD_PIPE_DEPTH-1:0] pipe_reg, pipe_next;
   lcd_rail_s out_reg, out_next;
   logic last_pos_reg, last_pos_next;
   logic [7:0] zrun_reg, zrun_next;
   logic lcv_reg, lcv_next;
   logic pulse, is_e3, viol;
   logic [7:0] zlimit;

   assign pulse = i_line.pos | i_line.neg;
   assign is_e3 = (i_rate_mode == LCD_RATE_E3);
   // a pulse of the same polarity as the previous one is a violation
   assign viol = pulse && !(i_line.pos && i_line.neg) && (i_line.pos == last_pos_reg);
   assign zlimit = is_e3 ? 8'(LCD_HDB3_LEN) : 8'(LCD_B3ZS_LEN);

   always_comb begin
      pipe_next = {pipe_reg[LCD_PIPE_DEPTH-2:0], i_line};
      out_next = pipe_reg[LCD_PIPE_DEPTH-1];
      last_pos_next = pulse ? i_line.pos : last_pos_reg;
      zrun_next = pulse ? 8'h00 : ((zrun_reg == 8'hff) ? zrun_reg : zrun_reg + 8'h01);
      lcv_next = 1'b0;
      if (i_line.pos && i_line.neg) begin
         lcv_next = 1'b1;
      end else if (viol && !bypass) begin
         if (is_e3) begin
            pipe_next[0] = '0;
            pipe_next[1] = '0;
            pipe_next[2] = '0;
            pipe_next[3] = '0;
            // the two bits before V must be zero in 000V and B00V
            lcv_next = pipe_reg[0] != '0 || pipe_reg[1] != '0;
         end else begin
            pipe_next[0] = '0;
            pipe_next[1] = '0;
            pipe_next[2] = '0;
            lcv_next = pipe_reg[0] != '0;
         end
      end else if (viol) begin
         lcv_next = 1'b1;
      end
      // one pulse per zero run, at the bit that reaches the limit
      if (!pulse && !bypass && zrun_reg == zlimit - 8'h01) begin
         lcv_next = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pipe_reg <= '0;
         out_reg <= '0;
         last_pos_reg <= 1'b0;
         zrun_reg <= '0;
         lcv_reg <= 1'b0;
      end else begin
         pipe_reg <= pipe_next;
         out_reg <= out_next;
         last_pos_reg <= last_pos_next;
         zrun_reg <= zrun_next;
         lcv_reg <= lcv_next;
      end
   end

   assign o_data = out_reg;
   assign o_code_violation_pulse = lcv_reg;

   // ****************************************************************
   // analog loss: synchroniser and hysteresis
   // ****************************************************************
   logic [1:0] below_sync_reg, above_sync_reg;
   logic alos_next;

   always_comb begin
      alos_next = alos_reg;
      if (below_sync_reg[1]) begin
         alos_next = 1'b1;
      end else if (above_sync_reg[1]) begin
         alos_next = 1'b0;
      end
      if (alos_dis) begin
         alos_next = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         below_sync_reg <= '0;
         above_sync_reg <= '0;
         alos_reg <= 1'b0;
      end else begin
         below_sync_reg <= {below_sync_reg[0], i_amp_below_declare};
         above_sync_reg <= {above_sync_reg[0], i_amp_above_clear};
         alos_reg <= alos_next;
      end
   end

   // ****************************************************************
   // digital loss: zero run declares, dense windows clear
   // ****************************************************************
   lcd_dlos_e dl_reg, dl_next;
   logic [4:0] win_reg, win_next;
   logic [5:0] ones_reg, ones_next;
   logic [2:0] good_reg, good_next;
   logic [7:0] zdecl;
   logic win_end, win_ok;

   // E3 declares sooner so that the loss output lands inside its window
   assign zdecl = is_e3 ? 8'(LCD_E3_ZEROS) : 8'(DLOS_ZEROS);
   assign win_end = (win_reg == 5'(LCD_WIN_BITS - 1));
   assign win_ok = (ones_reg + {5'h00, pulse}) >= 6'(LCD_WIN_MIN_ONES);

   always_comb begin
      dl_next = dl_reg;
      win_next = win_reg + 5'h01;
      ones_next = ones_reg + {5'h00, pulse};
      good_next = good_reg;
      if (win_end) begin
         ones_next = '0;
      end
      case (dl_reg)
         LCD_DL_OK: begin
            win_next = '0;
            ones_next = '0;
            good_next = '0;
            // a run that outlasted a disabled detector still declares once enabled
            if (!pulse && zrun_reg >= zdecl - 8'h01) begin
               dl_next = LCD_DL_LOST;
            end
         end
         LCD_DL_LOST: begin
            if (win_end) begin
               good_next = win_ok ? good_reg + 3'h1 : 3'h0;
               // E3 needs one window to stay within the clear bound
               if (win_ok && (is_e3 || good_reg == 3'(LCD_WIN_GOOD - 1))) begin
                  dl_next = LCD_DL_OK;
               end
            end
         end
         default: dl_next = LCD_DL_OK;
      endcase
      if (dlos_dis) begin
         dl_next = LCD_DL_OK;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dl_reg <= LCD_DL_OK;
         win_reg <= '0;
         ones_reg <= '0;
         good_reg <= '0;
      end else begin
         dl_reg <= dl_next;
         win_reg <= win_next;
         ones_reg <= ones_next;
         good_reg <= good_next;
      end
   end

   assign dlos_q = (dl_reg == LCD_DL_LOST);

   // ****************************************************************
   // combined loss of signal
   // ****************************************************************
   logic los_raw, los_next;
   logic [7:0] qual_reg, qual_next;

   assign los_raw = alos_reg | dlos_q;

   always_comb begin
      los_next = los_reg;
      qual_next = '0;
      if (!is_e3) begin
         los_next = los_raw;
      end else if (los_raw != los_reg) begin
         // E3 filter keeps the change inside the 10 to 255 UI window
         qual_next = qual_reg + 8'h01;
         if (qual_reg == 8'(E3_QUAL - 1)) begin
            los_next = los_raw;
            qual_next = '0;
         end
      end
      if (alos_dis && dlos_dis) begin
         los_next = 1'b0;
      end
      events = '0;
      events[LCD_IRQ_LCV] = lcv_reg;
      events[LCD_IRQ_LOS_SET] = los_next && !los_reg;
      events[LCD_IRQ_LOS_CLR] = !los_next && los_reg;
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         los_reg <= 1'b0;
         qual_reg <= '0;
      end else begin
         los_reg <= los_next;
         qual_reg <= qual_next;
      end
   end

   assign o_loss_of_signal_out = los_reg;

   // ****************************************************************
   // assertions
   // ****************************************************************
   property p_hdb3_run;
      @(posedge i_clk) disable iff (!i_rstn)
      (is_e3 && !bypass && !pulse && zrun_reg == 8'h03) |=> o_code_violation_pulse;
   endproperty
   a_hdb3_run: assert property (p_hdb3_run) else $error("missing HDB3 zero-run violation");

   property p_b3zs_run;
      @(posedge i_clk) disable iff (!i_rstn)
      (!is_e3 && !bypass && !pulse && zrun_reg == 8'h02) |=> o_code_violation_pulse;
   endproperty
   a_b3zs_run: assert property (p_b3zs_run) else $error("missing B3ZS zero-run violation");

   property p_hdb3_subst;
      @(posedge i_clk) disable iff (!i_rstn)
      (is_e3 && !bypass && viol) |-> ##5 (o_data == '0);
   endproperty
   a_hdb3_subst: assert property (p_hdb3_subst) else $error("HDB3 V not removed");

   property p_bypass_pass;
      @(posedge i_clk) disable iff (!i_rstn)
      (bypass && i_line.pos && !i_line.neg) ##1 bypass[*4] |-> ##1 o_data.pos;
   endproperty
   a_bypass_pass: assert property (p_bypass_pass) else $error("bypass lost a pulse");

   property p_dlos_declare;
      @(posedge i_clk) disable iff (!i_rstn)
      (!is_e3 && !dlos_dis && !pulse && zrun_reg == 8'(DLOS_ZEROS - 1)) |=> dlos_q;
   endproperty
   a_dlos_declare: assert property (p_dlos_declare) else $error("digital loss late");

   property p_ds3_or;
      @(posedge i_clk) disable iff (!i_rstn)
      (!is_e3 && !(alos_dis && dlos_dis)) |=> (los_reg == $past(alos_reg | dlos_q));
   endproperty
   a_ds3_or: assert property (p_ds3_or) else $error("loss is not analog OR digital");

   property p_alos_read;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_rd && i_addr == LCD_OFS_STATUS) |=> (o_rd_data[LCD_ST_ALOS] == $past(alos_reg));
   endproperty
   a_alos_read: assert property (p_alos_read) else $error("status D2 wrong");

   property p_alos_sync;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_amp_below_declare && !alos_dis) ##1 !alos_dis[*2] |=> alos_reg;
   endproperty
   a_alos_sync: assert property (p_alos_sync) else $error("analog loss not set");

   property p_both_off;
      @(posedge i_clk) disable iff (!i_rstn)
      (alos_dis && dlos_dis) |=> !o_loss_of_signal_out;
   endproperty
   a_both_off: assert property (p_both_off) else $error("loss with both detectors off");

   property p_e3_min;
      @(posedge i_clk) disable iff (!i_rstn)
      (is_e3 && $rose(los_raw) && !los_reg) ##1 is_e3[*8] |-> !o_loss_of_signal_out;
   endproperty
   a_e3_min: assert property (p_e3_min) else $error("E3 loss declared too early");
endmodule

/* File: hdl/lcd_pkg.sv */
// constants, types and register map of the line code decoder and loss monitor
package lcd_pkg;
   typedef enum logic [2:0] {
      LCD_RATE_E3 = 3'b001,
      LCD_RATE_DS3 = 3'b010,
      LCD_RATE_STS1 = 3'b100
   } lcd_rate_e;

   typedef enum logic [1:0] {
      LCD_DL_OK = 2'b01,
      LCD_DL_LOST = 2'b10
   } lcd_dlos_e;

   typedef struct packed {
      logic pos;
      logic neg;
   } lcd_rail_s;

   // register word indices
   localparam logic [2:0] LCD_OFS_STATUS = 3'h0;
   localparam logic [2:0] LCD_OFS_CONTROL = 3'h1;
   localparam logic [2:0] LCD_OFS_IRQ_STATUS = 3'h2;
   localparam logic [2:0] LCD_OFS_IRQ_MASK = 3'h3;
   localparam int LCD_REG_W = 5;
   localparam logic [4:0] LCD_CONTROL_RESET = 5'h00;

   // receive status fields
   localparam int LCD_ST_DRIVE_MON = 0;
   localparam int LCD_ST_DLOS = 1;
   localparam int LCD_ST_ALOS = 2;
   localparam int LCD_ST_LOS = 3;
   localparam int LCD_ST_LOCK = 4;
   // receive control fields
   localparam int LCD_CT_EQ_EN = 0;
   localparam int LCD_CT_DLOS_DIS = 1;
   localparam int LCD_CT_ALOS_DIS = 2;
   localparam int LCD_CT_BYPASS = 3;
   // interrupt status fields
   localparam int LCD_IRQ_LCV = 0;
   localparam int LCD_IRQ_LOS_SET = 1;
   localparam int LCD_IRQ_LOS_CLR = 2;

   // substitution lengths and zero-run limits, in bits
   localparam int LCD_HDB3_LEN = 4;
   localparam int LCD_B3ZS_LEN = 3;
   localparam int LCD_PIPE_DEPTH = LCD_HDB3_LEN;

   // digital loss figures, one unit interval per recovered clock
   localparam int LCD_DLOS_ZEROS = 160;
   localparam int LCD_WIN_BITS = 32;
   localparam int LCD_WIN_MIN_ONES = 10;
   localparam int LCD_WIN_GOOD = 4;
   // E3 loss timing window in unit intervals
   localparam int LCD_E3_MIN_UI = 10;
   localparam int LCD_E3_MAX_UI = 255;
   localparam int LCD_E3_ZEROS = 32;
   localparam int LCD_E3_QUAL_UI = 16;
endpackage

/* File: verification/lcd_line_tx.sv */
// far-end line transmitter model: AMI marks, deliberate violations and spaces
`timescale 1ns/100ps
module lcd_line_tx
   import lcd_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [1:0] i_sym,
   output lcd_rail_s o_line
);
   logic pol_reg;
   // 1 sends a mark of alternating polarity, 2 repeats the last polarity
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pol_reg <= 1'b0;
         o_line <= '0;
      end else if (i_sym == 2'h1) begin
         pol_reg <= ~pol_reg;
         o_line <= {~pol_reg, pol_reg};
      end else if (i_sym == 2'h2) begin
         o_line <= {pol_reg, ~pol_reg};
      end else begin
         o_line <= '0;
      end
   end
endmodule

/* File: verification/line_code_decoder_los_monitor_test.sv */
// self-checking bench for one receive channel
`timescale 1ns/100ps
module line_code_decoder_los_monitor_test;
   import lcd_pkg::*;
   localparam logic [31:0] SKIP = 32'hffffffff;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   lcd_rate_e rate = LCD_RATE_DS3;
   logic host = 1'b1;
   logic byp = 1'b0;
   logic below = 1'b0;
   logic above = 1'b1;
   logic lol = 1'b0;
   logic dmon = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [4:0] wdata = 5'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [1:0] sym = 2'h1;
   logic win_in = 1'b0;
   logic [5:0] win_q = 6'h00;
   logic [31:0] ones = 32'h0;
   logic [31:0] viols = 32'h0;
   logic [31:0] mismatches = 32'h0;
   logic [31:0] tests_run = 32'h0;
   logic [4:0] rdata;
   lcd_rail_s line;
   lcd_rail_s dout;
   logic viol;
   logic los;
   logic eq;
   logic irq;

   always #2 clk = ~clk;

   lcd_line_tx u_lcd_line_tx (.i_clk(clk), .i_rstn(rstn), .i_sym(sym), .o_line(line));
   lcd_channel u_lcd_channel (
      .i_clk(clk), .i_rstn(rstn), .i_rate_mode(rate), .i_host_mode(host),
      .i_codec_bypass(byp), .i_line(line), .i_amp_below_declare(below),
      .i_amp_above_clear(above), .i_lock_loss_flag(lol), .i_drive_monitor_flag(dmon),
      .i_addr(addr), .i_wr_data(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rd_data(rdata),
      .o_data(dout), .o_code_violation_pulse(viol), .o_loss_of_signal_out(los),
      .o_equalizer_enable(eq), .o_irq(irq)
   );

   // six stages: one transmitter register plus five of decoder latency
   always @(negedge clk) begin
      win_q <= {win_q[4:0], win_in};
      if (win_q[5]) ones <= ones + {31'h0, dout.pos | dout.neg};
      viols <= viols + {31'h0, viol};
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic end_sim();
      if (mismatches == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [4:0] v);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [2:0] a, input logic [4:0] e);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      chk({27'h0, rdata}, {27'h0, e});
      @(posedge clk);
   endtask

   task automatic look(input logic e_los, input logic e_irq);
      @(negedge clk);
      chk({31'h0, los}, {31'h0, e_los});
      chk({31'h0, irq}, {31'h0, e_irq});
      @(posedge clk);
   endtask

   task automatic send_n(input logic [1:0] c, input int n);
      repeat (n) begin
         sym <= c;
         @(posedge clk);
      end
   endtask

   task automatic send_str(input string s);
      for (int i = 0; i < s.len(); i++) begin
         sym <= (s[i] == "m") ? 2'h1 : (s[i] == "v") ? 2'h2 : 2'h0;
         @(posedge clk);
      end
   endtask

   // z space, m alternating mark, v same-polarity pulse
   task automatic pat(input string s, input logic [31:0] e_ones, input logic [31:0] e_viol);
      logic [31:0] v0;
      v0 = viols;
      ones = 32'h0;
      win_in <= 1'b1;
      send_str(s);
      win_in <= 1'b0;
      send_n(2'h1, 10);
      if (e_ones !== SKIP) chk(ones, e_ones);
      if (e_viol !== SKIP) chk(viols - v0, e_viol);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs();
      lol <= 1'b1;
      dmon <= 1'b1;
      send_n(2'h1, 4);
      rd(LCD_OFS_STATUS, 5'h11);
      rd(LCD_OFS_CONTROL, LCD_CONTROL_RESET);
      wr(LCD_OFS_CONTROL, 5'h07);
      rd(LCD_OFS_CONTROL, 5'h07);
      chk({31'h0, eq}, 32'h1);
      wr(LCD_OFS_STATUS, 5'h00);
      rd(LCD_OFS_STATUS, 5'h11);
      rd(3'h5, 5'h00);
      wr(LCD_OFS_CONTROL, 5'h00);
      lol <= 1'b0;
      dmon <= 1'b0;
   endtask

   task automatic t_decode();
      rate <= LCD_RATE_E3;
      send_n(2'h1, 8);
      pat("zzmzzzvmmmzzvmzz", 32'd4, 32'd0);
      pat("mzzzzm", SKIP, 32'd1);
      pat("mmv", SKIP, 32'd1);
      wr(LCD_OFS_CONTROL, 5'h08);
      pat("zzmzzzvmmmzzvmzz", 32'd7, SKIP);
      wr(LCD_OFS_CONTROL, 5'h00);
      host <= 1'b0;
      byp <= 1'b1;
      pat("zzmzzzvmmmzzvmzz", 32'd7, SKIP);
      byp <= 1'b0;
      pat("zzmzzzvmmmzzvmzz", 32'd4, 32'd0);
      host <= 1'b1;
      rate <= LCD_RATE_DS3;
      send_n(2'h1, 8);
      pat("zzmzzvmmmzvmzz", 32'd4, 32'd0);
      rate <= LCD_RATE_STS1;
      pat("mzzzm", SKIP, 32'd1);
      rate <= LCD_RATE_DS3;
   endtask

   task automatic t_dlos();
      rd(LCD_OFS_IRQ_STATUS, 5'h01);
      wr(LCD_OFS_IRQ_MASK, 5'h06);
      send_n(2'h0, 120);
      look(1'b0, 1'b0);
      send_n(2'h0, 80);
      look(1'b1, 1'b1);
      rd(LCD_OFS_STATUS, 5'h0a);
      wr(LCD_OFS_IRQ_MASK, 5'h00);
      look(1'b1, 1'b0);
      wr(LCD_OFS_IRQ_MASK, 5'h06);
      look(1'b1, 1'b1);
      rd(LCD_OFS_IRQ_STATUS, 5'h03);
      look(1'b1, 1'b0);
      // too few marks for four windows whatever the window phase
      send_n(2'h1, 70);
      look(1'b1, 1'b0);
      // long enough to hold one whole bad window at any phase
      send_n(2'h0, 64);
      send_n(2'h1, 100);
      look(1'b1, 1'b0);
      send_n(2'h1, 80);
      look(1'b0, 1'b1);
      rd(LCD_OFS_IRQ_STATUS, 5'h05);
      wr(LCD_OFS_IRQ_MASK, 5'h00);
   endtask

   task automatic t_alos();
      below <= 1'b1;
      above <= 1'b0;
      send_n(2'h1, 6);
      look(1'b1, 1'b0);
      rd(LCD_OFS_STATUS, 5'h0c);
      below <= 1'b0;
      send_n(2'h1, 6);
      look(1'b1, 1'b0);
      above <= 1'b1;
      send_n(2'h1, 6);
      look(1'b0, 1'b0);
      rd(LCD_OFS_STATUS, 5'h00);
      wr(LCD_OFS_CONTROL, 5'h04);
      below <= 1'b1;
      above <= 1'b0;
      send_n(2'h1, 6);
      look(1'b0, 1'b0);
      wr(LCD_OFS_CONTROL, 5'h06);
      send_n(2'h0, 200);
      look(1'b0, 1'b0);
      rd(LCD_OFS_STATUS, 5'h00);
      below <= 1'b0;
      above <= 1'b1;
      wr(LCD_OFS_CONTROL, 5'h00);
      send_n(2'h1, 200);
   endtask

   // early checks land before 10 UI and late ones just past 255 UI so a fastest or slowest legal response still passes
   task automatic t_e3();
      rate <= LCD_RATE_E3;
      send_n(2'h1, 50);
      send_n(2'h0, 9);
      look(1'b0, 1'b0);
      send_n(2'h0, 248);
      look(1'b1, 1'b0);
      send_n(2'h1, 9);
      look(1'b1, 1'b0);
      send_n(2'h1, 248);
      look(1'b0, 1'b0);
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_regs();
      t_decode();
      t_dlos();
      t_alos();
      t_e3();
      end_sim();
   end

   initial begin
      #100000;
      mismatches = mismatches + 1;
      end_sim();
   end
endmodule
